//--- hw/atpr_pkg.sv
// constants and register map of the analog terminal parameter bank
package atpr_pkg;
  localparam int REG_W = 16;
  localparam int IDX_W = 6;
  localparam int ARR_N = 38;

  // register indices
  localparam logic [5:0] REG_ADC_RAW = 6'h00;
  localparam logic [5:0] REG_DIAG = 6'h06;
  localparam logic [5:0] REG_CMD = 6'h07;
  localparam logic [5:0] REG_TYPE = 6'h08;
  localparam logic [5:0] REG_FW = 6'h09;
  localparam logic [5:0] REG_SRLEN = 6'h0A;
  localparam logic [5:0] REG_CHCNT = 6'h0B;
  localparam logic [5:0] REG_MINLEN = 6'h0C;
  localparam logic [5:0] REG_LAYOUT = 6'h0D;
  localparam logic [5:0] REG_ALIGN = 6'h0F;
  localparam logic [5:0] REG_HWREV = 6'h10;
  localparam logic [5:0] REG_FIN_OFS = 6'h11;
  localparam logic [5:0] REG_FIN_GAIN = 6'h12;
  localparam logic [5:0] REG_FOUT_OFS = 6'h13;
  localparam logic [5:0] REG_FOUT_GAIN = 6'h14;
  localparam logic [5:0] REG_UPPER = 6'h15;
  localparam logic [5:0] REG_LOWER = 6'h16;
  localparam logic [5:0] REG_CODE = 6'h1F;
  localparam logic [5:0] REG_FEAT = 6'h20;
  localparam logic [5:0] REG_UIN_OFS = 6'h21;
  localparam logic [5:0] REG_UIN_GAIN = 6'h22;
  localparam logic [5:0] REG_UDEF = 6'h23;
  localparam logic [5:0] REG_UOUT_OFS = 6'h24;
  localparam logic [5:0] REG_UOUT_GAIN = 6'h25;

  // fixed and reset values
  localparam logic [15:0] SRLEN_VAL = 16'h0130;
  localparam logic [15:0] CHCNT_VAL = 16'h0218;
  localparam logic [15:0] MINLEN_VAL = 16'h9898;
  localparam logic [15:0] LAYOUT_VAL = 16'h0004;
  localparam logic [15:0] ALIGN_RST = 16'h7F80;
  localparam logic [15:0] FIN_GAIN_RST = 16'h1080;
  localparam logic [15:0] FOUT_OFS_RST = 16'h0800;
  localparam logic [15:0] FOUT_GAIN_RST = 16'h7D00;
  localparam logic [15:0] UGAIN_RST = 16'h0100;
  localparam logic [15:0] FEAT_RST = 16'h0404;
  localparam logic [15:0] FEAT_MASK = 16'h1F0F;
  localparam logic [15:0] CODE_UNLOCK = 16'h1235;
  localparam logic [15:0] ZERO_W = 16'h0000;

  // feature bit positions
  localparam int FB_FALLBACK = 12;
  localparam int FB_OUT_FMT = 11;
  localparam int FB_OUT_WDT = 10;
  localparam int FB_OUT_FBYP = 9;
  localparam int FB_OUT_USCAL = 8;
  localparam int FB_IN_FMT = 3;
  localparam int FB_IN_WDT = 2;
  localparam int FB_IN_FBYP = 1;
  localparam int FB_IN_USCAL = 0;

  // control / status byte fields
  localparam int CB_REGCOM = 7;
  localparam int CB_WRITE = 6;
  localparam int SB_ACK = 7;
  localparam int DG_OVER = 0;
  localparam int DG_UNDER = 1;

  // gain shifts
  localparam int FIN_SHIFT = 12;
  localparam int FOUT_SHIFT = 15;
  localparam int USER_SHIFT = 8;

  // watchdog timing
  localparam longint WD_TIME_MS = 100;
  localparam longint CLK_PERIOD_NS = 5;
  localparam longint WD_CYCLES_DFLT = WD_TIME_MS * 1000000 / CLK_PERIOD_NS;
endpackage : atpr_pkg

//--- hw/atpr_regbank.sv
// parameter register bank of the one-in one-out analog terminal
`timescale 1ns/100ps

module atpr_regbank #(
  parameter logic [15:0] TERM_TYPE_ID = 16'h0ABC, // arbitrary value
  parameter logic [15:0] FW_REV = 16'h3030, // arbitrary value
  parameter logic [15:0] HW_REV = 16'h0000, // arbitrary value
  parameter longint WD_CYCLES = atpr_pkg::WD_CYCLES_DFLT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pi_strobe,
  input wire logic [7:0] ctrl_byte,
  input wire logic [atpr_pkg::REG_W-1:0] out_word,
  input wire logic [atpr_pkg::REG_W-1:0] adc_raw,
  input wire logic nvm_ld_valid,
  input wire logic [atpr_pkg::IDX_W-1:0] nvm_ld_idx,
  input wire logic [atpr_pkg::REG_W-1:0] nvm_ld_data,
  output logic [7:0] status_byte,
  output logic [atpr_pkg::REG_W-1:0] in_word,
  output logic [atpr_pkg::REG_W-1:0] dac_code,
  output logic watchdog_expired,
  output logic nvm_wr_strobe,
  output logic [atpr_pkg::IDX_W-1:0] nvm_wr_idx,
  output logic [atpr_pkg::REG_W-1:0] nvm_wr_data
);
  import atpr_pkg::*;

  if (WD_CYCLES < 1 || WD_CYCLES > 64'h00000000FFFFFFFF) begin : g_chk
    $error("atpr_regbank: watchdog cycle count out of range");
  end

  localparam logic [31:0] WD_LIMIT = 32'(WD_CYCLES - 1);
  localparam logic [15:0] FIN_ONE = 16'h0001 << FIN_SHIFT; // unity gain

  // registers that hold a nonvolatile copy and sit behind the code word
  function automatic logic atpr_protected(input logic [5:0] i);
    return (i >= REG_FIN_OFS && i <= REG_LOWER) ||
           (i >= REG_FEAT && i <= REG_UOUT_GAIN);
  endfunction : atpr_protected

  // reset value of each storage slot
  function automatic logic [15:0] atpr_rst_val(input int i);
    case (6'(i))
      REG_ALIGN: return ALIGN_RST;
      REG_FIN_GAIN: return FIN_GAIN_RST;
      REG_FOUT_OFS: return FOUT_OFS_RST;
      REG_FOUT_GAIN: return FOUT_GAIN_RST;
      REG_FEAT: return FEAT_RST;
      REG_UIN_GAIN: return UGAIN_RST;
      REG_UOUT_GAIN: return UGAIN_RST;
      default: return ZERO_W;
    endcase
  endfunction : atpr_rst_val

  // gain and offset: (x * g) >>> sh + o, truncated to the word
  function automatic logic [15:0] atpr_scale(input logic [15:0] x,
      input logic [15:0] g, input logic [15:0] o, input int sh);
    logic signed [32:0] p;
    logic signed [32:0] s;
    p = $signed(x) * $signed({1'b0, g});
    s = p >>> sh;
    return 16'(s[15:0] + o);
  endfunction : atpr_scale

  logic [15:0] prm [0:ARR_N-1];
  logic [7:0] last_ctrl;
  logic [15:0] out_set;
  logic [7:0] ch_status;
  logic [31:0] wd_cnt;

  // request decode
  wire reg_mode = ctrl_byte[CB_REGCOM];
  wire [5:0] req_idx = ctrl_byte[5:0];
  wire take = clk_en && pi_strobe;
  wire new_req = take && reg_mode && (ctrl_byte != last_ctrl);
  wire wr_req = new_req && ctrl_byte[CB_WRITE];
  wire [15:0] code_word = prm[REG_CODE];
  wire unlocked = (code_word == CODE_UNLOCK);
  wire req_prot = atpr_protected(req_idx);
  wire req_free = (req_idx == REG_CMD) || (req_idx == REG_ALIGN) ||
                  (req_idx == REG_CODE);
  wire wr_ok = wr_req && (req_free || (req_prot && unlocked));
  wire wr_persist = wr_ok && req_prot;
  wire ld_ok = nvm_ld_valid && atpr_protected(nvm_ld_idx);

  // one write port: coupler write wins over a nonvolatile reload
  wire wen = wr_ok || (clk_en && ld_ok);
  wire [5:0] widx = wr_ok ? req_idx : nvm_ld_idx;
  wire [15:0] wraw = wr_ok ? out_word : nvm_ld_data;
  wire [15:0] wdat = (widx == REG_FEAT) ? (wraw & FEAT_MASK) : wraw;

  // named views of the stored parameters
  wire [15:0] feat = prm[REG_FEAT];
  wire [15:0] fin_ofs = prm[REG_FIN_OFS];
  wire [15:0] fin_gain = prm[REG_FIN_GAIN];
  wire [15:0] fout_ofs = prm[REG_FOUT_OFS];
  wire [15:0] fout_gain = prm[REG_FOUT_GAIN];
  wire [15:0] upper_lim = prm[REG_UPPER];
  wire [15:0] lower_lim = prm[REG_LOWER];
  wire [15:0] user_default = prm[REG_UDEF];

  // input path: factory, then user scaling, then clamp and format
  wire [15:0] in_fac = feat[FB_IN_FBYP] ? adc_raw :
      atpr_scale(adc_raw, fin_gain, fin_ofs, FIN_SHIFT);
  wire [15:0] in_usr = feat[FB_IN_USCAL] ?
      atpr_scale(in_fac, prm[REG_UIN_GAIN], prm[REG_UIN_OFS], USER_SHIFT) :
      in_fac;
  // a zero limit leaves that side unclamped, so the zero defaults clamp nothing
  wire over = (upper_lim != ZERO_W) &&
              ($signed(in_usr) > $signed(upper_lim));
  wire under = (lower_lim != ZERO_W) &&
               ($signed(in_usr) < $signed(lower_lim));
  wire [15:0] in_clamp = over ? upper_lim : (under ? lower_lim : in_usr);
  wire [15:0] in_fmt = feat[FB_IN_FMT] ?
      {in_clamp[15:3], 2'b00, over | under} : in_clamp;
  wire [7:0] next_ch_status = {6'h00, under, over};

  // output path: user scaling, then factory compensation
  wire [15:0] out_usr = feat[FB_OUT_USCAL] ?
      atpr_scale(out_set, prm[REG_UOUT_GAIN], prm[REG_UOUT_OFS], USER_SHIFT) :
      out_set;
  wire [15:0] out_fac = feat[FB_OUT_FBYP] ? out_usr :
      atpr_scale(out_usr, fout_gain, fout_ofs, FOUT_SHIFT);
  wire [15:0] out_fmt = feat[FB_OUT_FMT] ? {out_fac[15:3], 3'b000} : out_fac;
  wire [15:0] next_dac = feat[FB_FALLBACK] ? user_default :
                         (watchdog_expired ? ZERO_W : out_fmt);

  // watchdog runs only while enabled; any process-data exchange kicks it
  wire wd_on = feat[FB_OUT_WDT] || feat[FB_IN_WDT];
  wire wd_kick = take && !reg_mode;
  wire wd_hit = wd_on && (wd_cnt >= WD_LIMIT);

  // read selection; fixed values live here and cannot be written
  logic [15:0] rd_val;
  always_comb begin
    case (req_idx)
      REG_ADC_RAW: rd_val = adc_raw;
      REG_DIAG: rd_val = {8'h00, ch_status};
      REG_TYPE: rd_val = TERM_TYPE_ID;
      REG_FW: rd_val = FW_REV;
      REG_SRLEN: rd_val = SRLEN_VAL;
      REG_CHCNT: rd_val = CHCNT_VAL;
      REG_MINLEN: rd_val = MINLEN_VAL;
      REG_LAYOUT: rd_val = LAYOUT_VAL;
      REG_HWREV: rd_val = HW_REV;
      REG_CMD, REG_ALIGN, REG_CODE: rd_val = prm[req_idx];
      default: rd_val = (req_prot) ? prm[req_idx] : ZERO_W;
    endcase
  end

  // parameter storage; reset clears the code word and relocks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < ARR_N; i++) begin
        prm[i] <= atpr_rst_val(i);
      end
    end else if (wen) begin
      prm[widx] <= wdat; // command slot only stores
    end
  end

  // register-communication answer and process data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_byte <= 8'h00;
      in_word <= ZERO_W;
      last_ctrl <= 8'h00;
      out_set <= ZERO_W;
    end else if (take) begin
      last_ctrl <= ctrl_byte;
      if (reg_mode) begin
        status_byte <= {1'b1, 1'b0, req_idx};
        in_word <= rd_val;
      end else begin
        status_byte <= ch_status;
        in_word <= in_fmt;
        out_set <= out_word;
      end
    end
  end

  // nonvolatile write-out, one pulse per accepted protected write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nvm_wr_strobe <= 1'b0;
      nvm_wr_idx <= 6'h00;
      nvm_wr_data <= ZERO_W;
    end else if (clk_en) begin
      nvm_wr_strobe <= wr_persist;
      if (wr_persist) begin
        nvm_wr_idx <= req_idx;
        nvm_wr_data <= wdat;
      end
    end
  end

  // analog side state: status, dac code, watchdog
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch_status <= 8'h00;
      dac_code <= ZERO_W;
      wd_cnt <= 32'h00000000;
      watchdog_expired <= 1'b0;
    end else if (clk_en) begin
      ch_status <= next_ch_status;
      dac_code <= next_dac;
      if (wd_kick || !wd_on) begin
        wd_cnt <= 32'h00000000;
        watchdog_expired <= 1'b0;
      end else if (wd_hit) begin
        watchdog_expired <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 32'h00000001;
      end
    end
  end

  // locked write to feature leaves it unchanged
  unlock_gate_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (wr_req && req_idx == REG_FEAT && !unlocked && !ld_ok) |=>
      feat == $past(feat))
    else $error("locked feature write took effect");

  // accepted protected write pulses nonvolatile copy
  persist_write_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    wr_persist |=> nvm_wr_strobe && nvm_wr_idx == $past(req_idx) &&
      prm[$past(req_idx)] == nvm_wr_data)
    else $error("protected write not persisted");

  // code word is clear after restart
  code_reset_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(rst_n) |-> code_word == ZERO_W && !unlocked)
    else $error("code word survived restart");

  // answer carries ack and register number
  ack_echo_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && reg_mode) |=> status_byte == {2'b10, $past(req_idx)})
    else $error("register answer malformed");

  // over limit reports the upper limit
  over_clamp_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && !reg_mode && over && !feat[FB_IN_FMT]) |=>
      in_word == $past(upper_lim) && ch_status[DG_OVER])
    else $error("over range not clamped");

  // under limit reports the lower limit
  under_clamp_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && !reg_mode && under && !feat[FB_IN_FMT]) |=>
      in_word == $past(lower_lim) && ch_status[DG_UNDER])
    else $error("under range not clamped");

  // reserved feature bits stay zero after a write
  feat_reserved_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (wr_ok && req_idx == REG_FEAT) |=>
      feat == ($past(out_word) & FEAT_MASK))
    else $error("feature write not masked");

  // fallback bit forces the user default onto the output
  fallback_out_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (clk_en && feat[FB_FALLBACK]) |=> dac_code == $past(user_default))
    else $error("fallback value not applied");

  // fixed identification read back
  type_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && reg_mode && req_idx == REG_TYPE) |=> in_word == TERM_TYPE_ID)
    else $error("terminal type read wrong");

  // diagnostic read mirrors status in low byte
  diag_mirror_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && reg_mode && req_idx == REG_DIAG) |=>
      in_word == {8'h00, $past(ch_status)})
    else $error("diagnostic read wrong");

  // watchdog trips only while enabled
  wd_enable_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(watchdog_expired) |-> $past(wd_on) && $past(wd_cnt) == WD_LIMIT)
    else $error("watchdog tripped while disabled");

  // a low enable freezes the outputs and the watchdog count
  freeze_hold_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !clk_en |=> $stable(dac_code) && $stable(status_byte) &&
      $stable(in_word) && $stable(wd_cnt) && $stable(nvm_wr_strobe))
    else $error("state moved while clock enable low");

  // any process exchange clears the watchdog
  wd_kick_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (clk_en && wd_kick) |=> !watchdog_expired)
    else $error("watchdog not cleared by exchange");

  // expired watchdog parks the output at zero unless fallback is on
  wd_dac_zero_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (clk_en && watchdog_expired && !feat[FB_FALLBACK]) |=>
      dac_code == ZERO_W)
    else $error("expired watchdog left output driven");

  // firmware word is built in
  fw_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && reg_mode && req_idx == REG_FW) |=> in_word == FW_REV)
    else $error("firmware revision read wrong");

  // shift register length word is built in
  srlen_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && reg_mode && req_idx == REG_SRLEN) |=> in_word == SRLEN_VAL)
    else $error("data length read wrong");

  // layout code is built in
  layout_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && reg_mode && req_idx == REG_LAYOUT) |=> in_word == LAYOUT_VAL)
    else $error("layout code read wrong");

  // hardware revision is built in, writes cannot reach it
  hwrev_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && reg_mode && req_idx == REG_HWREV) |=> in_word == HW_REV)
    else $error("hardware revision read wrong");

  // command slot write starts nothing and persists nothing
  cmd_inert_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (wr_ok && req_idx == REG_CMD) |=> !nvm_wr_strobe && $stable(feat))
    else $error("command write had an effect");

  // refused protected write never reaches the nonvolatile copy
  locked_persist_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (wr_req && req_prot && !unlocked) |=> !nvm_wr_strobe)
    else $error("locked write persisted");

  // bypassed factory scaling passes the raw value through
  in_bypass_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && !reg_mode && feat[FB_IN_FBYP] && !feat[FB_IN_USCAL] &&
      !feat[FB_IN_FMT] && !over && !under) |=> in_word == $past(adc_raw))
    else $error("factory bypass altered input");

  // unity factory gain adds only the offset
  in_unity_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (take && !reg_mode && !feat[FB_IN_FBYP] && !feat[FB_IN_USCAL] &&
      !feat[FB_IN_FMT] && fin_gain == FIN_ONE && !over && !under) |=>
      in_word == $past(adc_raw + fin_ofs))
    else $error("unity input gain wrong");
endmodule : atpr_regbank

//--- testbench/atpr_coupler.sv
// coupler model that drives process image exchanges into the bank
`timescale 1ns/100ps
module atpr_coupler (
  input wire logic ref_clk,
  output logic pi_strobe,
  output logic [7:0] ctrl_byte,
  output logic [15:0] out_word
);
  initial begin
    pi_strobe = 1'b0;
    ctrl_byte = 8'h00;
    out_word = 16'h0000;
  end

  // one exchange, held over one edge, then the lines are scrambled
  task automatic xfer(input logic [7:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    pi_strobe = 1'b1;
    ctrl_byte = c;
    out_word = d;
    @(posedge ref_clk);
    #1;
    pi_strobe = 1'b0;
    ctrl_byte = ~c; // released lines must not look stale
    out_word = ~d;
  endtask : xfer
endmodule : atpr_coupler

//--- testbench/atpr_regbank_tb.sv
// self-checking bench for the analog terminal parameter bank
`timescale 1ns/100ps
module atpr_regbank_tb;
  import atpr_pkg::*;
  localparam logic [15:0] T_ID = 16'h0ABC; // arbitrary value
  localparam logic [15:0] FW_V = 16'h3241; // arbitrary value
  localparam logic [15:0] HW_V = 16'h0002; // arbitrary value
  logic ref_clk, rst_n, clk_en, nvm_ld_valid, watchdog_expired;
  logic nvm_wr_strobe, pi_strobe;
  logic [5:0] nvm_ld_idx, nvm_wr_idx;
  logic [7:0] ctrl_byte, status_byte;
  logic [15:0] out_word, adc_raw, nvm_ld_data, in_word, dac_code;
  logic [15:0] nvm_wr_data, r;
  logic [40:0] expq[$];
  logic [40:0] e;
  int fail_count, n_tests, i;

  atpr_coupler i_cpl (.ref_clk, .pi_strobe, .ctrl_byte, .out_word);
  atpr_regbank #(.TERM_TYPE_ID(T_ID), .FW_REV(FW_V), .HW_REV(HW_V),
    .WD_CYCLES(20)) i_dut (.ref_clk, .rst_n, .clk_en, .pi_strobe,
    .ctrl_byte, .out_word, .adc_raw, .nvm_ld_valid, .nvm_ld_idx,
    .nvm_ld_data, .status_byte, .in_word, .dac_code, .watchdog_expired,
    .nvm_wr_strobe, .nvm_wr_idx, .nvm_wr_data);

  always #2.5 ref_clk = ~ref_clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [15:0] x,
    input logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // note the expected answer, then hand the exchange to the coupler
  task automatic xact(input logic [7:0] c, input logic [15:0] d,
    input logic [7:0] st, input logic [15:0] w, input logic [15:0] m,
    input logic nv);
    expq.push_back({nv, st, w, m});
    i_cpl.xfer(c, d);
  endtask : xact

  task automatic rd(input logic [5:0] a, input logic [15:0] v);
    xact({2'b10, a}, ZERO_W, {2'b10, a}, v, 16'hFFFF, 1'b0);
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [15:0] d,
    input logic nv);
    xact({2'b11, a}, d, {2'b10, a}, d, ZERO_W, nv);
  endtask : wr

  // write then read back, so two writes in a row never share a control byte
  task automatic wrc(input logic [5:0] a, input logic [15:0] d,
    input logic [15:0] v, input logic nv);
    xact({2'b11, a}, d, {2'b10, a}, v, ZERO_W, nv); // stored word
    rd(a, v);
  endtask : wrc

  // settle the converter value before the process exchange
  task automatic proc(input logic [15:0] adc, input logic [15:0] w,
    input logic [7:0] st);
    adc_raw = adc;
    repeat (4) @(posedge ref_clk);
    xact(8'h00, ZERO_W, st, w, 16'hFFFF, 1'b0);
  endtask : proc

  task automatic outp(input logic [15:0] d, input logic [15:0] v);
    xact(8'h00, d, 8'h00, ZERO_W, ZERO_W, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("dac_code", v, dac_code);
  endtask : outp

  // answer watcher: one note consumed per taken exchange
  always @(posedge ref_clk) begin
    if (rst_n === 1'b1 && pi_strobe === 1'b1) begin
      #2;
      e = expq.pop_front();
      chk("status_byte", {8'h00, e[39:32]}, {8'h00, status_byte});
      chk("in_word", e[31:16] & e[15:0], in_word & e[15:0]);
      chk("nvm_strobe", {15'h0000, e[40]},
        {15'h0000, nvm_wr_strobe});
      if (e[40]) begin
        chk("nvm_data", e[31:16], nvm_wr_data);
      end
    end
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    nvm_ld_valid = 1'b0;
    nvm_ld_idx = 6'h00;
    nvm_ld_data = ZERO_W;
    adc_raw = ZERO_W;
    void'($urandom(32'h040E));
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    rd(REG_FEAT, FEAT_RST);
    rd(REG_CODE, ZERO_W);
    rd(REG_TYPE, T_ID);
    rd(REG_FW, FW_V);
    rd(REG_SRLEN, SRLEN_VAL);
    rd(REG_CHCNT, CHCNT_VAL);
    rd(REG_MINLEN, MINLEN_VAL);
    rd(REG_LAYOUT, LAYOUT_VAL);
    rd(REG_FIN_GAIN, FIN_GAIN_RST);
    rd(REG_FOUT_GAIN, FOUT_GAIN_RST);
    rd(6'h3F, ZERO_W);
    wrc(REG_FW, 16'h5555, FW_V, 1'b0);
    wrc(REG_TYPE, 16'h5555, T_ID, 1'b0);
    wrc(REG_HWREV, 16'h5555, HW_V, 1'b0);
    wrc(REG_CMD, 16'h00A5, 16'h00A5, 1'b0);
    wrc(REG_FIN_GAIN, 16'h2000, FIN_GAIN_RST, 1'b0);
    wrc(REG_CODE, CODE_UNLOCK, CODE_UNLOCK, 1'b0);
    wrc(REG_FEAT, 16'hFFFF, FEAT_MASK, 1'b1);
    r = 16'($urandom());
    wrc(REG_UOUT_OFS, r, r, 1'b1);
    // restart in mid-run drops the code word
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    rd(REG_CODE, ZERO_W);
    wrc(REG_FEAT, ZERO_W, FEAT_RST, 1'b0);
    wrc(REG_FIN_OFS, 16'h0033, ZERO_W, 1'b0);
    nvm_ld_valid = 1'b1;
    nvm_ld_idx = REG_FIN_OFS;
    nvm_ld_data = 16'h0077;
    @(posedge ref_clk);
    #1;
    nvm_ld_valid = 1'b0;
    rd(REG_FIN_OFS, 16'h0077);
    // input path: unity factory gain, offset 5, limits +-256
    wr(REG_CODE, CODE_UNLOCK, 1'b0);
    wrc(REG_FIN_GAIN, 16'h1000, 16'h1000, 1'b1);
    wrc(REG_FIN_OFS, 16'h0005, 16'h0005, 1'b1);
    wrc(REG_UPPER, 16'h0100, 16'h0100, 1'b1);
    wrc(REG_LOWER, 16'hFF00, 16'hFF00, 1'b1);
    wrc(REG_UIN_GAIN, 16'h0200, 16'h0200, 1'b1);
    wrc(REG_FEAT, ZERO_W, ZERO_W, 1'b1);
    proc(16'h0040, 16'h0045, 8'h00);
    wrc(REG_FEAT, 16'h0002, 16'h0002, 1'b1);
    proc(16'h0200, 16'h0100, 8'h01);
    rd(REG_DIAG, 16'h0001);
    proc(16'hFE00, 16'hFF00, 8'h02);
    for (i = 0; i < 4; i++) begin
      r = 16'($urandom_range(255, 0));
      proc(r, r, 8'h00);
    end
    wrc(REG_FEAT, 16'h000A, 16'h000A, 1'b1);
    proc(16'h0200, 16'h0101, 8'h01);
    wrc(REG_FEAT, 16'h0003, 16'h0003, 1'b1);
    proc(16'h0040, 16'h0080, 8'h00);
    // output path
    wrc(REG_UDEF, 16'h0123, 16'h0123, 1'b1);
    wrc(REG_FEAT, 16'h1000, 16'h1000, 1'b1);
    outp(16'h7777, 16'h0123);
    wrc(REG_FEAT, 16'h0200, 16'h0200, 1'b1);
    outp(16'h1234, 16'h1234);
    wrc(REG_FEAT, 16'h0A00, 16'h0A00, 1'b1);
    outp(16'h1234, 16'h1230);
    wrc(REG_FEAT, 16'h0600, 16'h0600, 1'b1);
    outp(16'h1111, 16'h1111);
    repeat (30) @(posedge ref_clk);
    #1;
    chk("watchdog", 16'h0001, {15'h0000, watchdog_expired});
    chk("dac_code", ZERO_W, dac_code);
    outp(16'h2222, 16'h2222);
    chk("watchdog", ZERO_W, {15'h0000, watchdog_expired});
    // a low enable must stop the watchdog from counting out
    clk_en = 1'b0;
    repeat (30) @(posedge ref_clk);
    #1;
    chk("wd_frozen", ZERO_W, {15'h0000, watchdog_expired});
    clk_en = 1'b1;
    repeat (3) @(posedge ref_clk);
    close_out();
  end
endmodule : atpr_regbank_tb
